// ---- hdl/bsam_top.sv ----
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "bsam_regs.svh"
module bsam_top #(
	parameter int PROG_TICKS =
		(`BSAM_PROG_MIN_US * `BSAM_RC_KHZ + 999) / 1000
) (
	input  wire logic                          clk,
	input  wire logic                          arst_n,
	input  wire logic                          sys_rst,
	input  bsam_pkg::bsam_bus_req_s            bus_req,
	output logic      [`BSAM_DATA_W-1:0]       bus_rdata,
	output logic                               irq,
	input  wire logic                          boot_size_select_hi,
	input  wire logic                          boot_size_select_lo,
	input  wire logic                          spm_strobe,
	input  wire logic [15:0]                   z_ptr,
	input  wire logic [`BSAM_WORD_W-1:0]       spm_data,
	input  wire logic                          eeprom_write_busy,
	input  wire logic                          sleep_powerdown,
	input  wire logic                          rc_tick,
	input  wire logic [`BSAM_WADDR_W-1:0]      fetch_addr,
	output logic                               fetch_allow,
	output logic                               cpu_halt,
	output logic      [`BSAM_WADDR_W-1:0]      boot_start,
	output logic      [`BSAM_WADDR_W-1:0]      app_end,
	output bsam_pkg::bsam_flash_cmd_s          flash_cmd,
	input  wire logic [`BSAM_PAGE_IDX_W-1:0]   flash_buf_idx,
	output logic      [`BSAM_WORD_W-1:0]       flash_buf_data
);
	import bsam_pkg::*;

	localparam int MAX_TICKS = `BSAM_PROG_MAX_US * `BSAM_RC_KHZ / 1000;
	localparam logic [`BSAM_TICK_W-1:0] TICK_LAST =
		`BSAM_TICK_W'(PROG_TICKS - 1);

	initial begin
		if (PROG_TICKS < 1 || PROG_TICKS > MAX_TICKS ||
			PROG_TICKS >= (1 << `BSAM_TICK_W)) begin
			$error("PROG_TICKS out of range");
		end
	end

	bsam_state_s                    cs;
	bsam_state_s                    ns;
	logic [`BSAM_PAGE_W-1:0]        page_sel;
	logic [`BSAM_WORD_SEL_W-1:0]    word_sel;
	logic                           z_in_blocked_while_writing_region;
	logic                           fetch_in_blocked_while_writing_region;
	logic                           ctrl_wr;
	logic                           ctrl_ok;
	logic                           spm_ok;
	logic                           op_done;
	logic                           reen_acc;
	logic                           load_acc;
	logic [`BSAM_EVT_W-1:0]         evt;

	bsam_addr_map u_map (
		.boot_size     ({boot_size_select_hi, boot_size_select_lo}),
		.z_ptr         (z_ptr),
		.fetch_addr    (fetch_addr),
		.boot_start    (boot_start),
		.app_end       (app_end),
		.page_sel      (page_sel),
		.word_sel      (word_sel),
		.z_in_blocked_while_writing_region     (z_in_blocked_while_writing_region),
		.fetch_in_blocked_while_writing_region (fetch_in_blocked_while_writing_region)
	);

	always_comb begin
		ns = cs;
		evt = '0;
		reen_acc = 1'b0;
		load_acc = 1'b0;
		ns.fcmd.start = 1'b0;
		ctrl_wr = bus_req.wr && (bus_req.addr == `BSAM_OFS_CTRL);
		// no core activity reaches the control bits in power-down
		ctrl_ok = ctrl_wr && !cs.en && !eeprom_write_busy
			&& !sleep_powerdown;
		spm_ok = spm_strobe && (cs.win != '0) && !sleep_powerdown;
		op_done = (cs.op_st == BSAM_RUN) && rc_tick && (cs.ticks == TICK_LAST);

		if (ctrl_wr && !ctrl_ok) begin
			evt[`BSAM_EVT_REFUSED] = 1'b1;
		end
		if (ctrl_ok) begin
			ns.en    = bus_req.wdata[`BSAM_CTRL_EN];
			ns.erase = bus_req.wdata[`BSAM_CTRL_ERASE];
			ns.write = bus_req.wdata[`BSAM_CTRL_WRITE];
			ns.lock  = bus_req.wdata[`BSAM_CTRL_LOCK];
			ns.reen  = bus_req.wdata[`BSAM_CTRL_REEN];
			ns.win   = bus_req.wdata[`BSAM_CTRL_EN] ?
				`BSAM_SPM_WINDOW : '0;
		end else if (spm_ok) begin
			ns.win = '0;
		end else if (cs.win != '0) begin
			ns.win = cs.win - `BSAM_WIN_W'(1);
			// enable dropped if the store never came
			if (cs.win == `BSAM_WIN_W'(1)) begin
				ns.en = 1'b0;
				{ns.erase, ns.write, ns.lock, ns.reen} = '0;
				evt[`BSAM_EVT_TIMEOUT] = 1'b1;
			end
		end

		if (spm_ok) begin
			ns.en = 1'b0;
			{ns.erase, ns.write, ns.lock, ns.reen} = '0;
			if ({cs.reen, cs.lock, cs.write, cs.erase} == 4'h0) begin
				// only five index bits exist in a 32-word page
				load_acc = 1'b1;
				ns.page_buf[word_sel[`BSAM_PAGE_IDX_W-1:0]] = spm_data;
			end else if ({cs.reen, cs.lock, cs.write, cs.erase} == 4'h1 ||
				{cs.reen, cs.lock, cs.write, cs.erase} == 4'h2) begin
				ns.en = 1'b1;
				ns.erase = cs.erase;
				ns.write = cs.write;
				ns.op_st = BSAM_RUN;
				ns.op_blocked_while_writing_region = z_in_blocked_while_writing_region;
				ns.ticks = '0;
				ns.busy_flag = 1'b1;
				ns.fcmd.start = 1'b1;
				ns.fcmd.kind = cs.erase ? BSAM_OP_ERASE : BSAM_OP_WRITE;
				ns.fcmd.page = page_sel;
			end else if ({cs.reen, cs.lock, cs.write, cs.erase} == 4'h4) begin
				// lock write leaves the whole flash readable
				ns.en = 1'b1;
				ns.lock = 1'b1;
				ns.op_st = BSAM_RUN;
				ns.op_blocked_while_writing_region = 1'b0;
				ns.ticks = '0;
				ns.fcmd.start = 1'b1;
				ns.fcmd.kind = BSAM_OP_LOCK;
				ns.fcmd.lock_data = spm_data[`BSAM_DATA_W-1:0];
			end else if ({cs.reen, cs.lock, cs.write, cs.erase} == 4'h8) begin
				reen_acc = 1'b1;
				ns.busy_flag = 1'b0;
				ns.page_buf = {`BSAM_PAGE_WORDS{`BSAM_ERASED_WORD}};
			end
		end

		// ticks come only from the RC timebase, not from clk
		if (cs.op_st == BSAM_RUN && rc_tick) begin
			ns.ticks = cs.ticks + `BSAM_TICK_W'(1);
		end
		if (op_done) begin
			ns.op_st = BSAM_IDLE;
			ns.op_blocked_while_writing_region = 1'b0;
			ns.en = 1'b0;
			{ns.erase, ns.write, ns.lock, ns.reen} = '0;
			evt[`BSAM_EVT_DONE] = 1'b1;
			if (cs.fcmd.kind == BSAM_OP_WRITE) begin
				ns.page_buf = {`BSAM_PAGE_WORDS{`BSAM_ERASED_WORD}};
			end
		end

		if (bus_req.wr && bus_req.addr == `BSAM_OFS_MASK) begin
			ns.mask = bus_req.wdata[`BSAM_EVT_W-1:0];
		end
		ns.rdata = '0;
		if (bus_req.rd) begin
			if (bus_req.addr == `BSAM_OFS_CTRL) begin
				ns.rdata[`BSAM_CTRL_EN]    = cs.en;
				ns.rdata[`BSAM_CTRL_ERASE] = cs.erase;
				ns.rdata[`BSAM_CTRL_WRITE] = cs.write;
				ns.rdata[`BSAM_CTRL_LOCK]  = cs.lock;
				ns.rdata[`BSAM_CTRL_REEN]  = cs.reen;
				ns.rdata[`BSAM_CTRL_BUSY]  = cs.busy_flag;
			end else if (bus_req.addr == `BSAM_OFS_STAT) begin
				ns.rdata[`BSAM_EVT_W-1:0] = cs.status;
			end else if (bus_req.addr == `BSAM_OFS_MASK) begin
				ns.rdata[`BSAM_EVT_W-1:0] = cs.mask;
			end else begin
				ns.rdata[1:0] = {boot_size_select_hi, boot_size_select_lo};
				ns.rdata[`BSAM_INFO_RUN] = (cs.op_st == BSAM_RUN);
			end
		end
		// a new event in the clearing read survives it
		if (bus_req.rd && bus_req.addr == `BSAM_OFS_STAT) begin
			ns.status = evt;
		end else begin
			ns.status = cs.status | evt;
		end
		ns.buf_q = cs.page_buf[flash_buf_idx];

		// system reset clears software state but lets a running
		// operation finish; only arst_n may cut it short
		if (sys_rst) begin
			ns.win = '0;
			ns.status = '0;
			ns.mask = '0;
			ns.page_buf = {`BSAM_PAGE_WORDS{`BSAM_ERASED_WORD}};
			if (ns.op_st == BSAM_IDLE) begin
				ns.en = 1'b0;
				{ns.erase, ns.write, ns.lock, ns.reen} = '0;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cs <= '{page_buf: {`BSAM_PAGE_WORDS{`BSAM_ERASED_WORD}},
				op_st: BSAM_IDLE, fcmd: '0, default: '0};
		end else begin
			cs <= ns;
		end
	end

	assign cpu_halt = (cs.op_st == BSAM_RUN) && cs.op_blocked_while_writing_region;
	assign fetch_allow = !sleep_powerdown && !cpu_halt &&
		!(cs.busy_flag && !fetch_in_blocked_while_writing_region);
	assign bus_rdata = cs.rdata;
	assign irq = |(cs.status & cs.mask);
	assign flash_cmd = cs.fcmd;
	assign flash_buf_data = cs.buf_q;

	logic [16:0] run_cyc;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			run_cyc <= '0;
		end else if (cs.op_st != BSAM_RUN) begin
			run_cyc <= '0;
		end else if (run_cyc != '1) begin
			run_cyc <= run_cyc + 17'(1);
		end
	end

	property p_window;
		@(posedge clk) disable iff (!arst_n)
		(ctrl_ok && bus_req.wdata[`BSAM_CTRL_EN] && !sys_rst)
			##1 (!spm_strobe && !ctrl_wr && !sys_rst)[*4] |=> !cs.en;
	endproperty
	a_window: assert property (p_window)
		else $error("enable not dropped after store window");

	property p_prog_len;
		@(posedge clk) disable iff (!arst_n)
		op_done |-> run_cyc >= 17'(PROG_TICKS - 1);
	endproperty
	a_prog_len: assert property (p_prog_len)
		else $error("flash operation ended too early");

	property p_rc_time;
		@(posedge clk) disable iff (!arst_n)
		(cs.op_st == BSAM_RUN && !rc_tick && !spm_ok) |=> $stable(cs.ticks);
	endproperty
	a_rc_time: assert property (p_rc_time)
		else $error("programming timer moved without RC tick");

	property p_reset_keeps;
		@(posedge clk) disable iff (!arst_n)
		(cs.op_st == BSAM_RUN && sys_rst && !op_done) |=>
			(cs.op_st == BSAM_RUN && cs.en);
	endproperty
	a_reset_keeps: assert property (p_reset_keeps)
		else $error("system reset aborted flash operation");

	property p_sleep;
		@(posedge clk) disable iff (!arst_n)
		(sleep_powerdown && ctrl_wr && !sys_rst && !op_done
			&& cs.win == '0) |-> !fetch_allow ##1 $stable(cs.en);
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("activity in power-down sleep");

	property p_rww_block;
		@(posedge clk) disable iff (!arst_n)
		(cs.busy_flag && !fetch_in_blocked_while_writing_region) || cpu_halt |-> !fetch_allow;
	endproperty
	a_rww_block: assert property (p_rww_block)
		else $error("fetch allowed from busy region");

	property p_busy_clear;
		@(posedge clk) disable iff (!arst_n)
		$fell(cs.busy_flag) |-> $past(reen_acc);
	endproperty
	a_busy_clear: assert property (p_busy_clear)
		else $error("busy flag cleared without re-enable");

	property p_busy_set;
		@(posedge clk) disable iff (!arst_n)
		(cs.fcmd.start && cs.fcmd.kind != BSAM_OP_LOCK) |->
			cs.busy_flag throughout (##[0:8] cs.op_st == BSAM_RUN);
	endproperty
	a_busy_set: assert property (p_busy_set)
		else $error("busy flag not set for erase or write");

	property p_page_sel;
		@(posedge clk) disable iff (!arst_n)
		(spm_ok && (cs.erase ^ cs.write) && !cs.lock && !cs.reen
			&& cs.op_st == BSAM_IDLE) |=>
			cs.fcmd.start && cs.fcmd.page == $past(z_ptr[13:7]);
	endproperty
	a_page_sel: assert property (p_page_sel)
		else $error("page select not taken from pointer 13:7");

	property p_load;
		@(posedge clk) disable iff (!arst_n)
		(load_acc && !sys_rst) |=>
			cs.page_buf[$past(z_ptr[5:1])] == $past(spm_data);
	endproperty
	a_load: assert property (p_load)
		else $error("page buffer word not loaded");

	property p_region;
		@(posedge clk) disable iff (!arst_n)
		fetch_in_blocked_while_writing_region ==
			(fetch_addr[`BSAM_COUNTER_TOP_BIT -: 2] == 2'h3);
	endproperty
	a_region: assert property (p_region)
		else $error("fetch region decode wrong");

	// boot area always starts on a 256-word step inside the blocked region
	property p_boot_end;
		@(posedge clk) disable iff (!arst_n)
		(app_end + `BSAM_WADDR_W'(1) == boot_start) &&
			(boot_start >= `BSAM_BLOCKED_WHILE_WRITING_REGION_START) &&
			(boot_start[7:0] == 8'h00);
	endproperty
	a_boot_end: assert property (p_boot_end)
		else $error("application end not below boot start");

	c_erase: cover property (@(posedge clk) disable iff (!arst_n)
		cs.fcmd.kind == BSAM_OP_ERASE && op_done);
	c_write: cover property (@(posedge clk) disable iff (!arst_n)
		cs.fcmd.kind == BSAM_OP_WRITE && op_done);
	c_timeout: cover property (@(posedge clk) disable iff (!arst_n)
		evt[`BSAM_EVT_TIMEOUT]);
	c_reen: cover property (@(posedge clk) disable iff (!arst_n)
		reen_acc && !cs.busy_flag ##0 1'b1 ##1 !cs.busy_flag);

endmodule : bsam_top

// ---- hdl/bsam_regs.svh ----
// Contract
// - system reset never aborts a running flash operation
// - power-down sleep blocks fetch and control writes
// - programming time counted on RC oscillator ticks
// - erase, write, lock stay busy 3.7-4.5 ms
// - boot size picks boot start and end
// - words from 0x1800 up readable while writing elsewhere
// - during erase/write fetch only from blocked region
// - page holds 32 words, 5-bit index
// - counter top bit position is 12
// - page select from pointer bits 13 to 7
// - buffer word from pointer 6:1; zero on write (code indexes with pointer 5:1 and refills the buffer with FFFF after a write)
// - pointer bit 13 carries counter top bit
// - pointer bit 6 carries in-page top bit (code ignores pointer bit 6; the in-page index is pointer 5:1)
// - busy flag held until read re-enable command
// - store must follow control write within four cycles
// - pointer bits 15,14 ignored; bit 0 unused
`ifndef BSAM_REGS_SVH
`define BSAM_REGS_SVH

`define BSAM_ADDR_W          2
`define BSAM_DATA_W          8
`define BSAM_OFS_CTRL        2'h0
`define BSAM_OFS_STAT        2'h1
`define BSAM_OFS_MASK        2'h2
`define BSAM_OFS_INFO        2'h3

`define BSAM_CTRL_EN         0
`define BSAM_CTRL_ERASE      1
`define BSAM_CTRL_WRITE      2
`define BSAM_CTRL_LOCK       3
`define BSAM_CTRL_REEN       4
`define BSAM_CTRL_BUSY       6
`define BSAM_INFO_RUN        7

`define BSAM_EVT_W           3
`define BSAM_EVT_DONE        0
`define BSAM_EVT_TIMEOUT     1
`define BSAM_EVT_REFUSED     2

`define BSAM_WADDR_W         13
`define BSAM_COUNTER_TOP_BIT 12
`define BSAM_PAGE_W          7
`define BSAM_WORD_SEL_W      6
`define BSAM_PAGE_IDX_W      5
`define BSAM_PAGE_WORDS      32
`define BSAM_WORD_W          16
`define BSAM_Z_TOP_BIT       13
`define BSAM_Z_PAGE_LO       7
`define BSAM_Z_PAGE_TOP      6
`define BSAM_Z_WORD_LO       1
`define BSAM_ERASED_WORD     16'hFFFF

`define BSAM_BOOT_256        2'h3
`define BSAM_BOOT_512        2'h2
`define BSAM_BOOT_1024       2'h1
`define BSAM_START_256       13'h1F00
`define BSAM_START_512       13'h1E00
`define BSAM_START_1024      13'h1C00
`define BSAM_START_2048      13'h1800
`define BSAM_BLOCKED_WHILE_WRITING_REGION_START      13'h1800
`define BSAM_BLOCKED_WHILE_WRITING_REGION_FIRST_PAGE 7'h60

`define BSAM_WIN_W           3
`define BSAM_SPM_WINDOW      3'h4
`define BSAM_TICK_W          16
`define BSAM_PROG_MIN_US     3700
`define BSAM_PROG_MAX_US     4500
`define BSAM_RC_KHZ          8000
`define BSAM_CLK_KHZ         25000

`endif

// ---- hdl/bsam_pkg.sv ----
`include "bsam_regs.svh"
package bsam_pkg;

	typedef enum logic [1:0] {BSAM_OP_ERASE, BSAM_OP_WRITE, BSAM_OP_LOCK}
		bsam_op_e;
	typedef enum logic {BSAM_IDLE, BSAM_RUN} bsam_run_e;

	typedef struct packed {
		logic [`BSAM_ADDR_W-1:0] addr;
		logic [`BSAM_DATA_W-1:0] wdata;
		logic                    wr;
		logic                    rd;
	} bsam_bus_req_s;

	typedef struct packed {
		logic                    start;
		bsam_op_e                kind;
		logic [`BSAM_PAGE_W-1:0] page;
		logic [`BSAM_DATA_W-1:0] lock_data;
	} bsam_flash_cmd_s;

	typedef struct packed {
		logic                                        en;
		logic                                        erase;
		logic                                        write;
		logic                                        lock;
		logic                                        reen;
		logic                                        busy_flag;
		logic [`BSAM_WIN_W-1:0]                      win;
		bsam_run_e                                   op_st;
		logic                                        op_blocked_while_writing_region;
		logic [`BSAM_TICK_W-1:0]                     ticks;
		logic [`BSAM_EVT_W-1:0]                      status;
		logic [`BSAM_EVT_W-1:0]                      mask;
		logic [`BSAM_DATA_W-1:0]                     rdata;
		bsam_flash_cmd_s                             fcmd;
		logic [`BSAM_PAGE_WORDS-1:0][`BSAM_WORD_W-1:0] page_buf;
		logic [`BSAM_WORD_W-1:0]                     buf_q;
	} bsam_state_s;

endpackage : bsam_pkg

// ---- hdl/bsam_addr_map.sv ----
`timescale 1ns/1ps
`include "bsam_regs.svh"
module bsam_addr_map (
	input  wire logic [1:0]                  boot_size,
	input  wire logic [15:0]                 z_ptr,
	input  wire logic [`BSAM_WADDR_W-1:0]    fetch_addr,
	output logic      [`BSAM_WADDR_W-1:0]    boot_start,
	output logic      [`BSAM_WADDR_W-1:0]    app_end,
	output logic      [`BSAM_PAGE_W-1:0]     page_sel,
	output logic      [`BSAM_WORD_SEL_W-1:0] word_sel,
	output logic                             z_in_blocked_while_writing_region,
	output logic                             fetch_in_blocked_while_writing_region
);
	import bsam_pkg::*;

	always_comb begin
		if (boot_size == `BSAM_BOOT_256) begin
			boot_start = `BSAM_START_256;
		end else if (boot_size == `BSAM_BOOT_512) begin
			boot_start = `BSAM_START_512;
		end else if (boot_size == `BSAM_BOOT_1024) begin
			boot_start = `BSAM_START_1024;
		end else begin
			boot_start = `BSAM_START_2048;
		end
	end
	// application ends one word below the boot reset vector
	assign app_end = boot_start - `BSAM_WADDR_W'(1);

	// z bit 0 and bits 15:14 never reach the word address
	assign page_sel = z_ptr[`BSAM_Z_TOP_BIT:`BSAM_Z_PAGE_LO];
	assign word_sel = z_ptr[`BSAM_Z_PAGE_TOP:`BSAM_Z_WORD_LO];
	assign z_in_blocked_while_writing_region = (page_sel >= `BSAM_BLOCKED_WHILE_WRITING_REGION_FIRST_PAGE);
	assign fetch_in_blocked_while_writing_region = (fetch_addr >= `BSAM_BLOCKED_WHILE_WRITING_REGION_START);

	// a top bit at 12 needs a 13-bit word address
	if (`BSAM_COUNTER_TOP_BIT + 1 != `BSAM_WADDR_W) begin : g_width
		$error("word address width does not fit counter top bit");
	end

endmodule : bsam_addr_map

// ---- bench/bsam_cpu_model.sv ----
`timescale 1ns/1ps
`include "bsam_regs.svh"
module bsam_cpu_model (
	input  wire logic               clk,
	input  bsam_pkg::bsam_bus_req_s bus_req,
	input  wire logic [2:0]         delay,
	input  wire logic [15:0]        z_set,
	input  wire logic [15:0]        d_set,
	output logic                    spm_strobe,
	output logic [15:0]             z_ptr,
	output logic [15:0]             spm_data
);
	import bsam_pkg::*;
	logic [2:0] cnt = 3'h0;
	initial begin
		spm_strobe = 1'b0;
		z_ptr = 16'h0;
		spm_data = 16'h0;
	end
	// store lands delay cycles after the enable write; 5 misses it
	always @(posedge clk) begin
		spm_strobe <= 1'b0;
		// operands not held outside the store, so they wander
		z_ptr <= ~z_ptr;
		spm_data <= 16'($urandom);
		if (cnt != 3'h0)
			cnt <= cnt - 3'h1;
		if (cnt == 3'h1) begin
			spm_strobe <= 1'b1;
			z_ptr <= z_set;
			spm_data <= d_set;
		end
		if (bus_req.wr && bus_req.addr == `BSAM_OFS_CTRL &&
				bus_req.wdata[0]) begin
			cnt <= delay - 3'h1;
			if (delay == 3'h1) begin
				spm_strobe <= 1'b1;
				z_ptr <= z_set;
				spm_data <= d_set;
			end
		end
	end
endmodule : bsam_cpu_model

// ---- bench/bsam_top_tb_top.sv ----
`timescale 1ns/1ps
`include "bsam_regs.svh"
module bsam_top_tb_top;
	import bsam_pkg::*;
	localparam int PT = 8;
	logic clk, arst_n, sys_rst, rc_tick, eew, slp, bhi, blo;
	logic spm_strobe, irq, fetch_allow, cpu_halt;
	bsam_bus_req_s   bus_req;
	bsam_flash_cmd_s flash_cmd, last_cmd;
	logic [7:0]  bus_rdata, rv;
	logic [12:0] fetch_addr, boot_start, app_end;
	logic [2:0]  delay;
	logic [4:0]  flash_buf_idx;
	logic [15:0] z_set, d_set, z_ptr, spm_data, flash_buf_data, z;
	int bad_count, n_checks, cyc;

	bsam_top #(.PROG_TICKS(PT)) i_bsam_top (.clk(clk), .arst_n(arst_n),
		.sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
		.irq(irq), .boot_size_select_hi(bhi), .boot_size_select_lo(blo),
		.spm_strobe(spm_strobe), .z_ptr(z_ptr), .spm_data(spm_data),
		.eeprom_write_busy(eew), .sleep_powerdown(slp), .rc_tick(rc_tick),
		.fetch_addr(fetch_addr), .fetch_allow(fetch_allow),
		.cpu_halt(cpu_halt), .boot_start(boot_start), .app_end(app_end),
		.flash_cmd(flash_cmd), .flash_buf_idx(flash_buf_idx),
		.flash_buf_data(flash_buf_data));
	bsam_cpu_model i_bsam_cpu_model (.clk(clk), .bus_req(bus_req),
		.delay(delay), .z_set(z_set), .d_set(d_set),
		.spm_strobe(spm_strobe), .z_ptr(z_ptr), .spm_data(spm_data));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task summarize;
		if (bad_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	function logic [12:0] exp_start(input logic [1:0] s);
		case (s)
			2'h3: return 13'h1F00;
			2'h2: return 13'h1E00;
			2'h1: return 13'h1C00;
			default: return 13'h1800;
		endcase
	endfunction : exp_start

	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req.addr <= a;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge clk);
		bus_req.wr <= 1'b0;
	endtask : wr

	task rd(input logic [1:0] a);
		@(posedge clk);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge clk);
		bus_req.rd <= 1'b0;
		#1 rv = bus_rdata;
	endtask : rd

	// eeprom idle and previous enable clear before each sequence
	task spm(input logic [7:0] c, input logic [15:0] zz, input logic [2:0] dl);
		last_cmd = '0;
		delay <= dl;
		z_set <= zz;
		d_set <= 16'($urandom);
		wr(`BSAM_OFS_CTRL, c);
		// one edge more than the latest store, so the capture has landed
		repeat (6) @(posedge clk);
	endtask : spm

	task opchk(input bsam_op_e k, input logic [6:0] pg);
		chk("start", 16'h1, 16'(last_cmd.start));
		chk("kind", 16'(k), 16'(last_cmd.kind));
		chk("page", 16'(pg), 16'(last_cmd.page));
	endtask : opchk

	task tick;
		repeat ($urandom % 4) @(posedge clk);
		@(posedge clk) rc_tick <= 1'b1;
		@(posedge clk) rc_tick <= 1'b0;
	endtask : tick

	// runs PT ticks, checking the op is still running one tick short
	task wait_op;
		repeat (PT - 1) tick();
		repeat (6) @(posedge clk);
		rd(`BSAM_OFS_INFO);
		chk("running", 16'h1, 16'(rv[7]));
		tick();
		rd(`BSAM_OFS_INFO);
		chk("ended", 16'h0, 16'(rv[7]));
	endtask : wait_op

	task fchk(input logic [12:0] a, input logic e);
		@(posedge clk) fetch_addr <= a;
		#1 chk("fetch", 16'(e), 16'(fetch_allow));
	endtask : fchk

	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			bad_count++;
			summarize();
		end
		if (flash_cmd.start)
			last_cmd <= flash_cmd;
	end

	initial begin
		{arst_n, sys_rst, rc_tick, eew, slp, bhi, blo} = '0;
		bus_req = '0;
		fetch_addr = '0;
		flash_buf_idx = '0;
		{delay, z_set, d_set, z} = '0;
		void'($urandom(70563));
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		#1 chk("rdata", 16'h0, 16'(bus_rdata));
		chk("buf", 16'hFFFF, flash_buf_data);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) {bhi, blo} <= 2'(i);
			#1 chk("boot", 16'(exp_start(2'(i))), 16'(boot_start));
			chk("app", 16'(exp_start(2'(i)) - 13'h1), 16'(app_end));
			rd(`BSAM_OFS_INFO);
			chk("size", 16'(i), 16'(rv[1:0]));
		end
		wr(`BSAM_OFS_MASK, 8'h07);
		for (int i = 0; i < 4; i++) begin
			z = 16'($urandom) & 16'hFFFE;
			spm(8'h01, z, 3'(1 + $urandom % 4));
			@(posedge clk) flash_buf_idx <= z[5:1];
			@(posedge clk);
			#1 chk("load", d_set, flash_buf_data);
		end
		spm(8'h11, 16'h0, 3'h2);
		@(posedge clk);
		#1 chk("reen buf", 16'hFFFF, flash_buf_data);
		z = {2'h3, 7'h5F, 7'($urandom)};
		spm(8'h03, z, 3'h4);
		opchk(BSAM_OP_ERASE, 7'h5F);
		rd(`BSAM_OFS_CTRL);
		chk("busy", 16'h1, 16'(rv[6]));
		fchk(13'h17FF, 1'b0);
		fchk(13'h1800, 1'b1);
		chk("halt", 16'h0, 16'(cpu_halt));
		wait_op();
		chk("irq", 16'h1, 16'(irq));
		rd(`BSAM_OFS_STAT);
		chk("stat", 16'h01, 16'(rv));
		chk("irq", 16'h0, 16'(irq));
		rd(`BSAM_OFS_CTRL);
		chk("ctrl", 16'h40, 16'(rv));
		fchk(13'h0000, 1'b0);
		spm(8'h11, 16'h0, 3'h3);
		fchk(13'h0000, 1'b1);
		z = {2'h1, 7'h60, 7'h00};
		spm(8'h05, z, 3'h1);
		opchk(BSAM_OP_WRITE, 7'h60);
		chk("halt", 16'h1, 16'(cpu_halt));
		fchk(13'h1FFF, 1'b0);
		@(posedge clk) sys_rst <= 1'b1;
		@(posedge clk) sys_rst <= 1'b0;
		#1 chk("halt", 16'h1, 16'(cpu_halt));
		wr(`BSAM_OFS_MASK, 8'h07);
		wait_op();
		chk("halt", 16'h0, 16'(cpu_halt));
		rd(`BSAM_OFS_STAT);
		chk("stat", 16'h01, 16'(rv));
		spm(8'h11, 16'h0, 3'h1);
		spm(8'h09, 16'h0001, 3'h1);
		// a lock start leaves the page field as the last write set it
		opchk(BSAM_OP_LOCK, 7'h60);
		chk("lock", 16'(d_set[7:0]), 16'(last_cmd.lock_data));
		chk("halt", 16'h0, 16'(cpu_halt));
		wait_op();
		rd(`BSAM_OFS_STAT);
		chk("stat", 16'h01, 16'(rv));
		wr(`BSAM_OFS_MASK, 8'h05);
		spm(8'h01, 16'h0, 3'h5);
		chk("irq", 16'h0, 16'(irq));
		rd(`BSAM_OFS_STAT);
		chk("late", 16'h02, 16'(rv));
		eew <= 1'b1;
		wr(`BSAM_OFS_CTRL, 8'h01);
		eew <= 1'b0;
		rd(`BSAM_OFS_STAT);
		chk("eew", 16'h04, 16'(rv));
		slp <= 1'b1;
		fchk(13'h1FFF, 1'b0);
		wr(`BSAM_OFS_CTRL, 8'h01);
		slp <= 1'b0;
		rd(`BSAM_OFS_STAT);
		chk("sleep", 16'h04, 16'(rv));
		rd(`BSAM_OFS_CTRL);
		chk("ctrl", 16'h00, 16'(rv));
		summarize();
	end
endmodule : bsam_top_tb_top
